// >>> rtl/pic_controller.sv
`timescale 1ns/100ps
module pic_controller
    import pic_pkg::*;
(
    // Clock and reset
    input wire logic I_CLOCK,
    input wire logic I_ARST_N,
    // CPU bus
    input wire logic I_CS_N,
    input wire logic I_RD_N,
    input wire logic I_WR_N,
    input wire logic I_REG_SELECT,
    input wire logic [7:0] I_DATA,
    output logic [7:0] O_DATA,
    output logic O_DATA_OE,
    // Interrupt requests and acknowledge
    input wire logic [7:0] I_REQUEST_IN,
    input wire logic I_IRQ_ACK_N,
    output logic O_INT,
    // Cascade
    input wire logic [2:0] I_CASCADE_ID,
    output logic [2:0] O_CASCADE_ID,
    output logic O_CASCADE_OE,
    input wire logic I_MASTER_STRAP
);
    pic_init_t init_state, next_init;
    pic_init_word_first_t init_word_first;
    pic_init_word_fourth_t init_word_fourth;
    logic [7:0] init_word_second, init_word_third, level_mask, pending_request_status, in_service_status, req_prev;
    logic [7:0] next_irr, next_isr, isr_set, isr_clr, irr_clr;
    logic read_isr, poll_mode, wr_prev, ack_prev;
    logic [1:0] ack_cnt;
    logic [2:0] lvl_q, res_lvl, isr_top;
    logic lvl_valid_q, res_valid, isr_any;
    logic [7:0] next_data;
    logic next_oe;

    // Bus decode
    wire logic ready = (init_state == PIC_READY);
    wire logic wr_start = !I_CS_N && !I_WR_N && wr_prev;
    wire logic rd_active = !I_CS_N && !I_RD_N && I_WR_N;
    wire logic wr_cmd = wr_start && (I_REG_SELECT == RS_CMD);
    wire logic wr_dat = wr_start && (I_REG_SELECT == RS_DATA);
    wire logic wr_init_word_first = wr_cmd && I_DATA[INIT_WORD_FIRST_BIT];
    wire logic wr_operation_word_eoi_priority = wr_cmd && ready && !I_DATA[INIT_WORD_FIRST_BIT]
        && !I_DATA[OPERATION_WORD_READ_SELECT_BIT];
    wire logic wr_operation_word_read_select = wr_cmd && ready && !I_DATA[INIT_WORD_FIRST_BIT]
        && I_DATA[OPERATION_WORD_READ_SELECT_BIT];
    wire pic_operation_word_eoi_priority_t operation_word_eoi_priority = pic_operation_word_eoi_priority_t'(I_DATA);
    wire pic_operation_word_read_select_t operation_word_read_select = pic_operation_word_read_select_t'(I_DATA);

    wire logic ack_fall = ack_prev && !I_IRQ_ACK_N;
    wire logic ack_rise = !ack_prev && I_IRQ_ACK_N;
    wire logic first_fall = ack_fall && (ack_cnt == 2'h0);
    wire logic cpu16 = init_word_fourth.cpu16;
    wire logic last_pulse = cpu16 ? (ack_cnt == 2'h1) : (ack_cnt == 2'h2);
    wire logic isr_pulse = cpu16 ? (ack_cnt == 2'h0) : (ack_cnt == 2'h1);
    wire logic [2:0] act_lvl = first_fall ? res_lvl : lvl_q;
    wire logic act_valid = first_fall ? res_valid : lvl_valid_q;

    // master from single mode, buffered bit or strap
    wire logic is_master = init_word_first.sngl
        || (init_word_fourth.buf_mode ? init_word_fourth.master : I_MASTER_STRAP);
    // who answers the address or vector bytes
    wire logic resp_bytes = init_word_first.sngl || (is_master && !init_word_third[lvl_q])
        || (!is_master && (I_CASCADE_ID == init_word_third[2:0]));

    always_comb begin
        res_lvl = SPURIOUS_LVL;
        res_valid = 1'b0;
        isr_top = SPURIOUS_LVL;
        isr_any = 1'b0;
        for (int i = 7; i >= 0; i--) begin
            if (pending_request_status[i] && !level_mask[i]) begin
                res_lvl = 3'(i);
                res_valid = 1'b1;
            end
            if (in_service_status[i]) begin
                isr_top = 3'(i);
                isr_any = 1'b1;
            end
        end
    end

    // request must outrank anything in service
    wire logic qualifies = res_valid && (!isr_any || res_lvl < isr_top);
    wire logic [7:0] poll_word = {qualifies, 4'h0, res_lvl};

    // 8-bit pending clear on second pulse rise
    // 16-bit pending clear on first pulse
    assign irr_clr = (ack_rise && isr_pulse && lvl_valid_q)
        ? (8'h01 << lvl_q) : 8'h00;
    assign isr_set = (ack_fall && isr_pulse && act_valid)
        ? (8'h01 << act_lvl) : 8'h00;
    // auto end on last pulse rise
    // same for the shorter 16-bit sequence
    // otherwise only an end command clears
    assign isr_clr = (ack_rise && last_pulse && init_word_fourth.auto_end_of_irq && lvl_valid_q)
        ? (8'h01 << lvl_q)
        : (wr_operation_word_eoi_priority && operation_word_eoi_priority.eoi_kind == EOI_SPEC) ? (8'h01 << operation_word_eoi_priority.level)
        : (wr_operation_word_eoi_priority && operation_word_eoi_priority.eoi_kind == EOI_NONSPEC && isr_any)
        ? (8'h01 << isr_top) : 8'h00;
    assign next_isr = (in_service_status & ~isr_clr) | isr_set;

    for (genvar g = 0; g < 8; g++) begin : g_sense
        wire logic hit = init_word_first.ltim ? I_REQUEST_IN[g]
            : (I_REQUEST_IN[g] && !req_prev[g]);
        wire logic keep = pending_request_status[g] && !irr_clr[g]
            && (!init_word_first.ltim || I_REQUEST_IN[g]);
        assign next_irr[g] = keep || hit;
    end

    always_comb begin
        next_init = init_state;
        unique case (init_state)
            PIC_READY: next_init = PIC_READY;
            PIC_WAIT_INIT_WORD_SECOND: next_init = !init_word_first.sngl ? PIC_WAIT_INIT_WORD_THIRD
                : init_word_first.ic4 ? PIC_WAIT_INIT_WORD_FOURTH : PIC_READY;
            PIC_WAIT_INIT_WORD_THIRD: next_init = init_word_first.ic4 ? PIC_WAIT_INIT_WORD_FOURTH : PIC_READY;
            PIC_WAIT_INIT_WORD_FOURTH: next_init = PIC_READY;
        endcase
    end

    // Output byte; data and enable are registered, so they lag by a cycle
    always_comb begin
        next_data = DATA_RESET;
        next_oe = 1'b0;
        if (!I_IRQ_ACK_N) begin
            // call opcode from the master only
            // one vector byte in 16-bit mode
            case (ack_cnt)
                2'h0: begin
                    next_data = CALL_OPCODE;
                    next_oe = !cpu16 && is_master;
                end
                2'h1: begin
                    next_data = cpu16 ? {init_word_second[7:3], lvl_q}
                        : init_word_first.adi ? {init_word_first.addr_a7_a5, lvl_q, 2'h0}
                        : {init_word_first.addr_a7_a5[2:1], lvl_q, 3'h0};
                    next_oe = resp_bytes;
                end
                default: begin
                    next_data = init_word_second;
                    next_oe = !cpu16 && resp_bytes;
                end
            endcase
        end else if (rd_active) begin
            next_oe = 1'b1;
            next_data = (I_REG_SELECT == RS_DATA) ? level_mask
                : poll_mode ? poll_word : read_isr ? in_service_status : pending_request_status;
        end
    end

    // nothing driven when idle, or when deselected outside an acknowledge
    always_ff @(posedge I_CLOCK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            O_DATA <= DATA_RESET;
            O_DATA_OE <= 1'b0;
            O_INT <= 1'b0;
        end else begin
            O_DATA <= next_data;
            O_DATA_OE <= next_oe;
            O_INT <= qualifies && ready;
        end
    end

    always_ff @(posedge I_CLOCK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            pending_request_status <= IRR_RESET;
            in_service_status <= ISR_RESET;
            req_prev <= REQ_PREV_RESET;
            wr_prev <= 1'b1;
            ack_prev <= 1'b1;
        end else begin
            pending_request_status <= next_irr;
            in_service_status <= next_isr;
            // Forces a fresh low-to-high edge after init
            req_prev <= wr_init_word_first ? REQ_PREV_RESET : I_REQUEST_IN;
            wr_prev <= I_WR_N;
            ack_prev <= I_IRQ_ACK_N;
        end
    end

    // master freezes level and drives slave identity
    always_ff @(posedge I_CLOCK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            ack_cnt <= 2'h0;
            lvl_q <= SPURIOUS_LVL;
            lvl_valid_q <= 1'b0;
            O_CASCADE_ID <= CAS_RESET;
        end else if (first_fall) begin
            lvl_q <= res_lvl;
            lvl_valid_q <= res_valid;
            // Only a master names a slave; a slave's word is its own id
            O_CASCADE_ID <= (is_master && !init_word_first.sngl && init_word_third[res_lvl])
                ? res_lvl : CAS_RESET;
        end else if (ack_rise) begin
            ack_cnt <= last_pulse ? 2'h0 : ack_cnt + 2'h1;
            if (last_pulse) begin
                O_CASCADE_ID <= CAS_RESET;
            end
        end
    end
    assign O_CASCADE_OE = is_master;

    // address-high writes follow the init sequence
    always_ff @(posedge I_CLOCK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            init_state <= PIC_READY;
            init_word_first <= pic_init_word_first_t'(INIT_WORD_FIRST_RESET);
            init_word_second <= INIT_WORD_SECOND_RESET;
            init_word_third <= INIT_WORD_THIRD_RESET;
            init_word_fourth <= pic_init_word_fourth_t'(INIT_WORD_FOURTH_RESET);
            level_mask <= MASK_RESET;
            read_isr <= 1'b0;
            poll_mode <= 1'b0;
        end else if (wr_init_word_first) begin
            init_state <= PIC_WAIT_INIT_WORD_SECOND;
            init_word_first <= pic_init_word_first_t'(I_DATA);
            init_word_third <= INIT_WORD_THIRD_RESET;
            level_mask <= MASK_RESET;
            read_isr <= 1'b0;
            poll_mode <= 1'b0;
            if (!I_DATA[0]) begin
                init_word_fourth <= pic_init_word_fourth_t'(INIT_WORD_FOURTH_RESET);
            end
        end else if (wr_dat) begin
            init_state <= next_init;
            unique case (init_state)
                PIC_READY: level_mask <= I_DATA;
                PIC_WAIT_INIT_WORD_SECOND: init_word_second <= I_DATA;
                PIC_WAIT_INIT_WORD_THIRD: init_word_third <= I_DATA;
                PIC_WAIT_INIT_WORD_FOURTH: init_word_fourth <= pic_init_word_fourth_t'(I_DATA);
            endcase
        end else if (wr_operation_word_read_select) begin
            poll_mode <= operation_word_read_select.poll;
            if (operation_word_read_select.read_reg) begin
                read_isr <= operation_word_read_select.read_isr;
            end
        end
    end

    default clocking @(posedge I_CLOCK); endclocking
    default disable iff (!I_ARST_N);

    call_opcode_a: assert property (
        (first_fall && !cpu16 && is_master) |=>
            (O_DATA == CALL_OPCODE) && O_DATA_OE)
        else $error("call opcode not driven on first ack");
    bus_float_a: assert property (
        (I_IRQ_ACK_N && (I_CS_N || (I_RD_N && I_WR_N))) |=> !O_DATA_OE)
        else $error("data bus driven while idle");
    status_read_a: assert property (
        (I_IRQ_ACK_N && rd_active && I_REG_SELECT == RS_CMD && !poll_mode)
            |=> O_DATA == (read_isr ? $past(in_service_status) : $past(pending_request_status)))
        else $error("wrong status byte read");
    edge_req_a: assert property (
        (!init_word_first.ltim && (I_REQUEST_IN & ~req_prev) != 8'h00) |=>
            ((pending_request_status & $past(I_REQUEST_IN & ~req_prev))
                == $past(I_REQUEST_IN & ~req_prev)))
        else $error("request edge lost");
    int_cause_a: assert property (
        $rose(O_INT) |-> $past(res_valid && ready))
        else $error("interrupt raised without a request");
    isr_16bit_a: assert property (
        (first_fall && cpu16 && res_valid) |=>
            in_service_status[$past(res_lvl)] && !irr_clr[$past(res_lvl)])
        else $error("16-bit first ack did not set in-service");
    float_16bit_a: assert property (
        (cpu16 && !I_IRQ_ACK_N && ack_cnt == 2'h0 && I_CS_N) |=> !O_DATA_OE)
        else $error("16-bit first ack drove the bus");
    auto_end_a: assert property (
        (ack_rise && !cpu16 && ack_cnt == 2'h2 && init_word_fourth.auto_end_of_irq
            && lvl_valid_q && !isr_set[lvl_q]) |=> !in_service_status[$past(lvl_q)])
        else $error("auto end did not clear in-service");
    mask_write_a: assert property (
        (wr_dat && ready) |=> level_mask == $past(I_DATA))
        else $error("mask write lost");
    cascade_dir_a: assert property (
        (first_fall && !is_master) |=>
            !O_CASCADE_OE && (O_CASCADE_ID == CAS_RESET))
        else $error("slave drives cascade pins");
endmodule

// >>> rtl/pic_pkg.sv
package pic_pkg;
    // Register select values
    localparam logic RS_CMD = 1'h0;
    localparam logic RS_DATA = 1'h1;
    // Command word decode bit positions
    localparam int INIT_WORD_FIRST_BIT = 4;
    localparam int OPERATION_WORD_READ_SELECT_BIT = 3;
    // Response bytes and special levels
    localparam logic [7:0] CALL_OPCODE = 8'hCD;
    localparam logic [2:0] SPURIOUS_LVL = 3'h7;
    localparam logic [2:0] EOI_NONSPEC = 3'h1;
    localparam logic [2:0] EOI_SPEC = 3'h3;
    // Reset values
    localparam logic [7:0] INIT_WORD_FIRST_RESET = 8'h00;
    localparam logic [7:0] INIT_WORD_SECOND_RESET = 8'h00;
    localparam logic [7:0] INIT_WORD_THIRD_RESET = 8'h07;
    localparam logic [7:0] INIT_WORD_FOURTH_RESET = 8'h00;
    localparam logic [7:0] MASK_RESET = 8'h00;
    localparam logic [7:0] IRR_RESET = 8'h00;
    localparam logic [7:0] ISR_RESET = 8'h00;
    localparam logic [7:0] REQ_PREV_RESET = 8'hFF;
    localparam logic [7:0] DATA_RESET = 8'h00;
    localparam logic [2:0] CAS_RESET = 3'h0;

    typedef enum logic [1:0] {
        PIC_READY = 2'b00,
        PIC_WAIT_INIT_WORD_SECOND = 2'b01,
        PIC_WAIT_INIT_WORD_THIRD = 2'b10,
        PIC_WAIT_INIT_WORD_FOURTH = 2'b11
    } pic_init_t;

    typedef struct packed {
        logic [2:0] addr_a7_a5;
        logic is_init_word_first;
        logic ltim;
        logic adi;
        logic sngl;
        logic ic4;
    } pic_init_word_first_t;

    typedef struct packed {
        logic [2:0] rsvd;
        logic sfnm;
        logic buf_mode;
        logic master;
        logic auto_end_of_irq;
        logic cpu16;
    } pic_init_word_fourth_t;

    typedef struct packed {
        logic [2:0] eoi_kind;
        logic [1:0] rsvd;
        logic [2:0] level;
    } pic_operation_word_eoi_priority_t;

    typedef struct packed {
        logic [2:0] rsvd;
        logic is_operation_word_read_select;
        logic rsvd2;
        logic poll;
        logic read_reg;
        logic read_isr;
    } pic_operation_word_read_select_t;
endpackage

// >>> tb/pic_cpu_model.sv
`timescale 1ns/100ps
module pic_cpu_model (
    // Clock and interrupt from the controller
    input wire logic i_clock,
    input wire logic i_int,
    // Acknowledge strobe back to the controller
    output logic o_irq_ack_n
);
    initial o_irq_ack_n = 1'b1;

    // Whole pulse train
    // Chip select is never touched here, so acknowledge runs deselected
    task automatic ack_seq(input int pulses, input int gap, output logic seen);
        int n;
        seen = 1'b0;
        for (n = 0; n < 50 && !seen; n++) begin
            @(negedge i_clock);
            seen = (i_int === 1'b1);
        end
        for (n = 0; n < pulses && seen; n++) begin
            o_irq_ack_n = 1'b0;
            repeat (gap) @(negedge i_clock);
            o_irq_ack_n = 1'b1;
            repeat (gap) @(negedge i_clock);
        end
    endtask
endmodule

// >>> tb/tb_pic_controller.sv
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin \
    tests_run++; \
    if ((got) !== (ex)) begin \
        fails++; \
        $display("MISMATCH %s exp %h got %h", nm, ex, got); \
    end \
end
module tb_pic_controller;
    import pic_pkg::*;
    logic clock = 1'b0;
    logic arst_n = 1'b0;
    logic cs_n = 1'b1;
    logic rd_n = 1'b1;
    logic wr_n = 1'b1;
    logic reg_sel = RS_CMD;
    logic [7:0] data_in = 8'h00;
    logic [7:0] req = 8'h00;
    logic [7:0] data_out;
    logic data_oe, irq, cas_oe, ack_n, seen;
    logic prev_oe = 1'b0;
    logic [2:0] cas_out;
    logic [2:0] cas_exp = 3'h0;
    logic [2:0] cas_in = 3'h5;
    logic strap = 1'b1;
    logic [7:0] exp_q[$];
    logic [7:0] m, init_word_second, init_word_fourth, mon_exp;
    int fails = 0;
    int tests_run = 0;
    int seed = 97645;
    int lvl, mode;

    always #12.5 clock = ~clock;

    pic_controller pic_controller_i (
        .I_CLOCK(clock),
        .I_ARST_N(arst_n),
        .I_CS_N(cs_n),
        .I_RD_N(rd_n),
        .I_WR_N(wr_n),
        .I_REG_SELECT(reg_sel),
        .I_DATA(data_in),
        .O_DATA(data_out),
        .O_DATA_OE(data_oe),
        .I_REQUEST_IN(req),
        .I_IRQ_ACK_N(ack_n),
        .O_INT(irq),
        .I_CASCADE_ID(cas_in),
        .O_CASCADE_ID(cas_out),
        .O_CASCADE_OE(cas_oe),
        .I_MASTER_STRAP(strap)
    );

    pic_cpu_model pic_cpu_model_i (
        .i_clock(clock),
        .i_int(irq),
        .o_irq_ack_n(ack_n)
    );

    task automatic finish_test;
        if (fails == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // strobes never overlap
    // WR goes high for a cycle so the next write sees a fresh edge
    task automatic wr(input logic a, input logic [7:0] d);
        @(negedge clock);
        cs_n = 1'b0;
        wr_n = 1'b0;
        reg_sel = a;
        data_in = d;
        @(negedge clock);
        cs_n = 1'b1;
        wr_n = 1'b1;
        @(negedge clock);
    endtask

    task automatic rd(input logic a, input logic [7:0] ex);
        exp_q.push_back(ex);
        @(negedge clock);
        cs_n = 1'b0;
        rd_n = 1'b0;
        reg_sel = a;
        repeat (3) @(negedge clock);
        cs_n = 1'b1;
        rd_n = 1'b1;
        repeat (2) @(negedge clock);
    endtask

    task automatic wait_int;
        int n;
        for (n = 0; n < 20 && irq !== 1'b1; n++) @(negedge clock);
    endtask

    // Every fresh bus drive is one result; a drive nobody expected fails
    always @(negedge clock) begin
        if (data_oe === 1'b1 && prev_oe !== 1'b1) begin
            mon_exp = (exp_q.size() > 0) ? exp_q.pop_front() : 8'hXX;
            `CHK("data", mon_exp, data_out)
            if (ack_n === 1'b0) begin
                `CHK("cascade_id", cas_exp, cas_out)
            end
        end
        prev_oe <= data_oe;
    end

    initial begin
        #(25ns * 20000);
        fails++;
        finish_test();
    end

    initial begin
        repeat (20) @(posedge clock);
        @(negedge clock);
        arst_n = 1'b1;
        `CHK("cascade_oe", 1'b1, cas_oe)
        init_word_second = $random(seed);
        for (mode = 0; mode < 5; mode++) begin
            init_word_fourth = (mode == 0) ? 8'h00 : (mode == 2) ? 8'h03 : 8'h02;
            // Pass 3 is a cascade master, pass 4 a slave with id 5
            strap = (mode != 4);
            lvl = {$random(seed)} % 7;
            wr(RS_CMD, (mode > 2) ? 8'hB1 : 8'hB7);
            wr(RS_DATA, init_word_second);
            if (mode > 2) begin
                wr(RS_DATA, (mode == 3) ? 8'h01 << lvl : 8'h05);
            end
            wr(RS_DATA, init_word_fourth);
            `CHK("cascade_dir", (mode != 4), cas_oe)
            m = $random(seed);
            wr(RS_DATA, m);
            rd(RS_DATA, m);
            wr(RS_DATA, 8'hFF);
            req = (8'h01 << lvl) | 8'h80;
            repeat (6) @(negedge clock);
            `CHK("int_masked", 1'b0, irq)
            wr(RS_CMD, 8'h0A);
            rd(RS_CMD, req);
            wr(RS_DATA, 8'h00);
            wait_int();
            `CHK("int_open", 1'b1, irq)
            cas_exp = (mode == 3) ? 3'(lvl) : 3'h0;
            if (mode == 2) begin
                exp_q.push_back({init_word_second[7:3], 3'(lvl)});
            end else begin
                if (mode != 4) begin
                    exp_q.push_back(CALL_OPCODE);
                end
                if (mode != 3) begin
                    exp_q.push_back((mode == 4) ? {2'b10, 3'(lvl), 3'b000}
                        : {3'b101, 3'(lvl), 2'b00});
                    exp_q.push_back(init_word_second);
                end
            end
            pic_cpu_model_i.ack_seq((mode == 2) ? 2 : 3, 2 + 3 * mode, seen);
            `CHK("int_seen", 1'b1, seen)
            wr(RS_CMD, 8'h0B);
            rd(RS_CMD, (mode == 0) ? 8'h01 << lvl : 8'h00);
            wr(RS_CMD, 8'h0A);
            rd(RS_CMD, 8'h80);
            if (mode == 0) begin
                wr(RS_CMD, 8'h20);
                wr(RS_CMD, 8'h0B);
                rd(RS_CMD, 8'h00);
            end
            req = 8'h00;
            `CHK("bus_idle", 1'b0, data_oe)
        end
        `CHK("all_seen", 1'b1, exp_q.size() == 0)
        finish_test();
    end
endmodule
